// File: inc/simil_cfg.svh
// Purpose: constants of the servo input and mode interlock block
// Assumes: 250 MHz aclk, 32-bit AXI4-Lite register bus
// Notes: byte addresses, field positions, reset values and timing counts
`ifndef SIMIL_CFG_SVH
`define SIMIL_CFG_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define SIMIL_ADDR_POLARITY 8'h00
`define SIMIL_ADDR_AUTO_ON 8'h04
`define SIMIL_ADDR_STOP_METHOD 8'h08
`define SIMIL_ADDR_OUT_ASSIGN 8'h0c
`define SIMIL_ADDR_IN_ASSIGN 8'h10
`define SIMIL_ADDR_HOME_METHOD 8'h14
`define SIMIL_ADDR_STATUS 8'h18

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SIMIL_POL_DIGIT_LSB 8
`define SIMIL_AUTO_DIGIT_LSB 8
`define SIMIL_AUTO_LIMITS_ON 4'h4
`define SIMIL_POLARITY_RST 16'h0000
`define SIMIL_AUTO_ON_RST 16'h0000
`define SIMIL_STOP_METHOD_RST 16'h0000
`define SIMIL_OUT_ASSIGN_RST 32'h0007_0000
`define SIMIL_IN_ASSIGN_RST 32'h7654_3210
`define SIMIL_HOME_METHOD_RST 3'h0
`define SIMIL_IN_UNASSIGNED 4'hf

// ----------------------------------------------------------------------
// output function codes
// ----------------------------------------------------------------------
`define SIMIL_OUT_NONE 8'h00
`define SIMIL_OUT_TROUBLE 8'h03
`define SIMIL_OUT_WARNING 8'h07
`define SIMIL_OUT_READY 8'h02
`define SIMIL_OUT_TRAVEL_DONE 8'h18

// ----------------------------------------------------------------------
// axi responses and timing
// ----------------------------------------------------------------------
`define SIMIL_RESP_OKAY 2'b00
`define SIMIL_RESP_SLVERR 2'b10
`define SIMIL_CLK_MHZ 250
`define SIMIL_DEBOUNCE_NS 1000
`define SIMIL_DEBOUNCE_CYC ((`SIMIL_DEBOUNCE_NS * `SIMIL_CLK_MHZ + 999) / 1000)

`endif

// File: inc/simil_pkg.sv
// Purpose: types of the servo input and mode interlock block
// Assumes: nothing beyond the config header
// Notes: mode states are one-hot
package simil_pkg;

  // operation mode, one-hot
  typedef enum logic [2:0] {
    SIMIL_MODE_MANUAL = 3'b001,
    SIMIL_MODE_AUTO = 3'b010,
    SIMIL_MODE_HOME = 3'b100
  } simil_mode_type;

  // home-return methods
  typedef enum logic [2:0] {
    SIMIL_HOME_DOG = 3'h0,
    SIMIL_HOME_COUNT = 3'h1,
    SIMIL_HOME_DATA_SET = 3'h2,
    SIMIL_HOME_STOPPER = 3'h3,
    SIMIL_HOME_IGNORANCE = 3'h4,
    SIMIL_HOME_DOG_REAR = 3'h5,
    SIMIL_HOME_COUNT_FRONT = 3'h6,
    SIMIL_HOME_DOG_CRADLE = 3'h7
  } simil_home_type;

endpackage

// File: core/simil_core.sv
// Purpose: input conditioning, mode selection and stop interlocks of a servo controller
// Assumes: in_pins are asynchronous field inputs; motion_busy, alarm_active,
//   travel_done, servo_on and program_has_home come from logic on aclk
// Notes: registers over AXI4-Lite, one aligned word each
//
// Behaviour
// [R1] select on: auto or home; off: manual
// [R2] three optional inputs pick program number
// [R3] host picks a program holding home command
// [R4] home ignorance: servo-on position becomes home
// [R5] eight selectable home-return methods offered
// [R6] forced-stop off: stop, cut drive, brake
// [R7] forced-stop back on clears stop state
// [R8] host holds forced-stop on before operating
// [R9] proximity detected when input off by default
// [R10] polarity digit: 0 off-detect, 1 on-detect
// [R11] both limits on permit motion, else lock
// [R12] stop behaviour on limit is configurable
// [R13] auto-on digit 4 forces both limits on
// [R14] unassigned limit input reads as on
// [R15] trouble output on unless alarm present
// [R16] input pin functions reassignable by parameters
// [R17] four output pins reassignable by parameters
// [R18] code 24 in second slot maps travel-done
// [R19] limit off raises warning, drops warning output
// [R20] all inputs synchronised and debounced first
// [R21] mode change waits until motion stopped
`include "simil_cfg.svh"
`timescale 1ns/1ps

module simil_core #(
  parameter int DEB_CYCLES = `SIMIL_DEBOUNCE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] in_pins,
  input wire logic motion_busy,
  input wire logic alarm_active,
  input wire logic travel_done,
  input wire logic servo_on,
  input wire logic program_has_home,
  output simil_pkg::simil_mode_type op_mode,
  output simil_pkg::simil_home_type home_method,
  output logic [2:0] program_select,
  output logic home_set_pulse,
  output logic proximity_detected,
  output logic power_stage_enable,
  output logic dynamic_brake_on,
  output logic sudden_stop,
  output logic slow_stop,
  output logic servo_lock,
  output logic motion_permit,
  output logic [3:0] out_pins
);

  // elaboration check: counter is 16 bits wide
  if (DEB_CYCLES < 1 || DEB_CYCLES > 65535) begin : g_bad_deb
    $error("DEB_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // input synchronisers and debouncers
  // ----------------------------------------------------------------------
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  // one debounced bit per generate pass, each with a single writer
  wire [7:0] clean_reg;

  // first stage feeds the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= in_pins;
      sync2_reg <= sync1_reg; // see [R20]
    end
  end

  // a pin changes only after staying at its new level for DEB_CYCLES
  for (genvar i = 0; i < 8; i++) begin : g_deb
    logic [15:0] cnt_reg;
    logic bit_reg;
    assign clean_reg[i] = bit_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_reg <= 16'h0000;
        bit_reg <= 1'b0;
      end else if (sync2_reg[i] == bit_reg) begin
        cnt_reg <= 16'h0000;
      end else if (cnt_reg == 16'(DEB_CYCLES - 1)) begin
        cnt_reg <= 16'h0000;
        bit_reg <= sync2_reg[i]; // see [R20]
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [15:0] polarity_reg;
  logic [15:0] auto_on_reg;
  logic [15:0] stop_method_reg;
  logic [31:0] out_assign_reg;
  logic [31:0] in_assign_reg;
  logic [2:0] home_method_reg;

  // ----------------------------------------------------------------------
  // input function routing
  // ----------------------------------------------------------------------
  // function slot order: select, program 0..2, forced stop, dog, fwd, rev
  wire [7:0] fn_level;
  wire [7:0] fn_assigned;
  for (genvar f = 0; f < 8; f++) begin : g_route
    wire [3:0] idx = in_assign_reg[4*f +: 4];
    assign fn_assigned[f] = (idx[3] == 1'b0); // see [R16]
    assign fn_level[f] = fn_assigned[f] ? clean_reg[idx[2:0]] : 1'b0;
  end

  wire auto_manual_select = fn_level[0];
  wire [2:0] program_select_inputs = fn_level[3:1]; // unassigned reads 0, see [R2]
  // an unassigned forced-stop reads as held on, so the drive is not locked out
  wire forced_stop_input = fn_assigned[4] ? fn_level[4] : 1'b1;
  wire dog_level = fn_level[5];
  wire auto_limits = auto_on_reg[`SIMIL_AUTO_DIGIT_LSB +: 4] == `SIMIL_AUTO_LIMITS_ON;
  wire forward_stroke_limit = auto_limits | !fn_assigned[6] | fn_level[6]; // see [R13] [R14]
  wire reverse_stroke_limit = auto_limits | !fn_assigned[7] | fn_level[7]; // see [R13] [R14]
  wire pol_on = polarity_reg[`SIMIL_POL_DIGIT_LSB]; // see [R10]
  wire dog_hit = pol_on ? dog_level : !dog_level; // see [R9] [R10]
  wire limit_stop = !(forward_stroke_limit & reverse_stroke_limit); // see [R11]

  // ----------------------------------------------------------------------
  // mode selection and interlocks
  // ----------------------------------------------------------------------
  simil_pkg::simil_mode_type mode_reg;
  simil_pkg::simil_mode_type mode_next;
  logic fstop_reg;
  logic servo_on_d_reg;
  logic warn_reg;

  // requested mode; home needs a program carrying the home command
  always_comb begin
    if (!auto_manual_select) begin
      mode_next = simil_pkg::SIMIL_MODE_MANUAL; // see [R1]
    end else if (program_has_home) begin
      mode_next = simil_pkg::SIMIL_MODE_HOME; // see [R1] [R3]
    end else begin
      mode_next = simil_pkg::SIMIL_MODE_AUTO; // see [R1]
    end
  end

  // mode is frozen while moving so a stroke is never cut by a mode flip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= simil_pkg::SIMIL_MODE_MANUAL;
    end else if (!motion_busy) begin
      mode_reg <= mode_next; // see [R21]
    end
  end

  // stop state follows the contact: open sets it, closed clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fstop_reg <= 1'b1;
      warn_reg <= 1'b0;
      servo_on_d_reg <= 1'b0;
    end else begin
      fstop_reg <= !forced_stop_input; // see [R6] [R7] [R8]
      warn_reg <= limit_stop; // see [R19]
      servo_on_d_reg <= servo_on;
    end
  end

  wire servo_on_rise = servo_on & !servo_on_d_reg;
  wire ignorance = home_method_reg == simil_pkg::SIMIL_HOME_IGNORANCE;
  wire stop_gentle = stop_method_reg[0];

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_stage_enable <= 1'b0;
      dynamic_brake_on <= 1'b1;
      sudden_stop <= 1'b0;
      slow_stop <= 1'b0;
      servo_lock <= 1'b0;
      motion_permit <= 1'b0;
      home_set_pulse <= 1'b0;
      proximity_detected <= 1'b0;
      program_select <= 3'h0;
    end else begin
      power_stage_enable <= forced_stop_input; // see [R6]
      dynamic_brake_on <= !forced_stop_input; // see [R6]
      sudden_stop <= limit_stop & !stop_gentle; // see [R11] [R12]
      slow_stop <= limit_stop & stop_gentle; // see [R12]
      servo_lock <= limit_stop; // see [R11]
      motion_permit <= forced_stop_input & !limit_stop & !alarm_active; // see [R11]
      home_set_pulse <= servo_on_rise & ignorance
                        & (mode_reg == simil_pkg::SIMIL_MODE_HOME); // see [R4]
      proximity_detected <= dog_hit; // see [R9]
      program_select <= program_select_inputs; // see [R2]
    end
  end

  assign op_mode = mode_reg;
  assign home_method = simil_pkg::simil_home_type'(home_method_reg); // see [R5]

  // ----------------------------------------------------------------------
  // output pin mapping
  // ----------------------------------------------------------------------
  function automatic logic out_sel(input logic [7:0] code, input logic [3:0] src);
    logic r;
    r = 1'b0;
    if (code == `SIMIL_OUT_TROUBLE) r = src[0];
    else if (code == `SIMIL_OUT_WARNING) r = src[1];
    else if (code == `SIMIL_OUT_TRAVEL_DONE) r = src[2];
    else if (code == `SIMIL_OUT_READY) r = src[3];
    return r;
  endfunction

  // trouble and warning are on when healthy
  wire [3:0] out_src = {power_stage_enable & !alarm_active, travel_done, !warn_reg,
                        !alarm_active}; // see [R15] [R18] [R19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pins <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        out_pins[p] <= out_sel(out_assign_reg[8*p +: 8], out_src); // see [R17] [R18]
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign s_axi_awready = !aw_held_reg & !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg & !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire do_write = aw_held_reg & w_held_reg & !s_axi_bvalid;
  wire wr_pol = awaddr_reg == `SIMIL_ADDR_POLARITY;
  wire wr_auto = awaddr_reg == `SIMIL_ADDR_AUTO_ON;
  wire wr_stop = awaddr_reg == `SIMIL_ADDR_STOP_METHOD;
  wire wr_oasg = awaddr_reg == `SIMIL_ADDR_OUT_ASSIGN;
  wire wr_iasg = awaddr_reg == `SIMIL_ADDR_IN_ASSIGN;
  wire wr_home = awaddr_reg == `SIMIL_ADDR_HOME_METHOD;
  wire wr_stat = awaddr_reg == `SIMIL_ADDR_STATUS;
  wire wr_hit = wr_pol | wr_auto | wr_stop | wr_oasg | wr_iasg | wr_home | wr_stat;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  wire [31:0] pol_m = merge({16'h0000, polarity_reg}, wdata_reg, wstrb_reg);
  wire [31:0] auto_m = merge({16'h0000, auto_on_reg}, wdata_reg, wstrb_reg);
  wire [31:0] stop_m = merge({16'h0000, stop_method_reg}, wdata_reg, wstrb_reg);
  wire [31:0] home_m = merge({29'h0, home_method_reg}, wdata_reg, wstrb_reg);

  // address and data may arrive in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIMIL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit & !wr_stat) ? `SIMIL_RESP_OKAY : `SIMIL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      polarity_reg <= `SIMIL_POLARITY_RST;
      auto_on_reg <= `SIMIL_AUTO_ON_RST;
      stop_method_reg <= `SIMIL_STOP_METHOD_RST;
      out_assign_reg <= `SIMIL_OUT_ASSIGN_RST;
      in_assign_reg <= `SIMIL_IN_ASSIGN_RST;
      home_method_reg <= `SIMIL_HOME_METHOD_RST;
    end else if (do_write) begin
      if (wr_pol) polarity_reg <= pol_m[15:0];
      if (wr_auto) auto_on_reg <= auto_m[15:0];
      if (wr_stop) stop_method_reg <= stop_m[15:0];
      if (wr_oasg) out_assign_reg <= merge(out_assign_reg, wdata_reg, wstrb_reg);
      if (wr_iasg) in_assign_reg <= merge(in_assign_reg, wdata_reg, wstrb_reg);
      if (wr_home) home_method_reg <= home_m[2:0];
    end
  end

  // read decode
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] status_word = {15'h0, limit_stop, warn_reg, fstop_reg, dog_hit,
                             reverse_stroke_limit, forward_stroke_limit, mode_reg,
                             clean_reg};
  wire rd_hit;
  wire [31:0] rd_word;
  assign rd_hit = (ra == `SIMIL_ADDR_POLARITY) | (ra == `SIMIL_ADDR_AUTO_ON)
                | (ra == `SIMIL_ADDR_STOP_METHOD) | (ra == `SIMIL_ADDR_OUT_ASSIGN)
                | (ra == `SIMIL_ADDR_IN_ASSIGN) | (ra == `SIMIL_ADDR_HOME_METHOD)
                | (ra == `SIMIL_ADDR_STATUS);
  assign rd_word = (ra == `SIMIL_ADDR_POLARITY) ? {16'h0, polarity_reg}
                 : (ra == `SIMIL_ADDR_AUTO_ON) ? {16'h0, auto_on_reg}
                 : (ra == `SIMIL_ADDR_STOP_METHOD) ? {16'h0, stop_method_reg}
                 : (ra == `SIMIL_ADDR_OUT_ASSIGN) ? out_assign_reg
                 : (ra == `SIMIL_ADDR_IN_ASSIGN) ? in_assign_reg
                 : (ra == `SIMIL_ADDR_HOME_METHOD) ? {29'h0, home_method_reg}
                 : (ra == `SIMIL_ADDR_STATUS) ? status_word
                 : 32'h0;

  // read answered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SIMIL_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `SIMIL_RESP_OKAY : `SIMIL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: dv/simil_checker.sv
// Purpose: port-level assertions for the interlock block
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound to simil_core at the foot of this file
`include "simil_cfg.svh"
`timescale 1ns/1ps

module simil_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic motion_busy,
  input wire simil_pkg::simil_mode_type op_mode,
  input wire simil_pkg::simil_home_type home_method,
  input wire logic home_set_pulse,
  input wire logic power_stage_enable,
  input wire logic dynamic_brake_on,
  input wire logic sudden_stop,
  input wire logic slow_stop,
  input wire logic motion_permit
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mode_one_hot: assert property ($onehot(op_mode))
    else $error("mode not one-hot");
  a_mode_frozen_busy: assert property (motion_busy |=> $stable(op_mode))
    else $error("mode changed while moving");
  a_brake_cuts_drive: assert property (dynamic_brake_on |-> !power_stage_enable)
    else $error("drive on with brake");
  a_stop_blocks_motion: assert property ((sudden_stop || slow_stop) |-> !motion_permit)
    else $error("motion permitted during stop");
  a_stop_kind_single: assert property (!(sudden_stop && slow_stop))
    else $error("two stop kinds at once");
  a_home_pulse_once: assert property (home_set_pulse |=> !home_set_pulse)
    else $error("home pulse too long");
  a_home_pulse_cause: assert property (home_set_pulse |->
    home_method == simil_pkg::SIMIL_HOME_IGNORANCE)
    else $error("home pulse in wrong method");
  a_write_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_blocks_addr: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  a_error_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `SIMIL_RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // main scenarios seen
  c_home_pulse: cover property (home_set_pulse);
  c_sudden: cover property (sudden_stop);
  c_slow: cover property (slow_stop);
endmodule

bind simil_core simil_checker u_chk (.*);

// File: dv/simil_field.sv
// Purpose: host controller and field switches beside the interlock block
// Assumes: switches are levels, changing off the clock edge
// Notes: glitch inverts every pin for one clock period
`timescale 1ns/1ps

module simil_field (
  input wire logic aclk,
  input wire logic [7:0] want_pins,
  input wire logic glitch,
  input wire logic want_home,
  output logic [7:0] in_pins,
  output logic program_has_home
);
  // forced-stop contact closed from power-up, before any operation
  initial begin
    in_pins = 8'hd0;
    program_has_home = 1'b0;
  end
  // contacts move asynchronously to aclk, so the sync chain is exercised
  always @(posedge aclk) begin
    #1.3;
    in_pins <= glitch ? ~want_pins : want_pins;
    program_has_home <= want_home;
  end
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the interlock block
// Assumes: pin functions f at pin f until reassigned
// Notes: short debounce keeps the run brief
`include "simil_cfg.svh"
`timescale 1ns/1ps

module testbench;
  localparam int DEB = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, in_pins, want_pins = 8'hd0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pol, aon, stp, oa, ia, hm;
  logic [3:0] s_axi_wstrb = 4'hf, out_pins;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, motion_busy = 0, alarm_active = 0, travel_done = 0, servo_on = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic program_has_home, want_home = 0, glitch = 0, home_set_pulse, proximity_detected;
  logic power_stage_enable, dynamic_brake_on, sudden_stop, slow_stop, servo_lock;
  logic motion_permit;
  logic [2:0] program_select, mode_exp;
  simil_pkg::simil_mode_type op_mode;
  simil_pkg::simil_home_type home_method;
  int fail_count = 0;
  int num_checks = 0;

  always #2 aclk = ~aclk;
  simil_core #(.DEB_CYCLES(DEB)) DUT (.*);
  simil_field u_field (.*);

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic timeout(input int n);
    if (n >= 50) begin
      fail_count++;
      $display("unexpected at %0t: bus timeout", $time);
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // model of the register file and the interlocks
  // ----------------------------------------------------------------
  function automatic logic [31:0] regval(input logic [7:0] a);
    case (a)
      `SIMIL_ADDR_POLARITY: return pol;
      `SIMIL_ADDR_AUTO_ON: return aon;
      `SIMIL_ADDR_STOP_METHOD: return stp;
      `SIMIL_ADDR_OUT_ASSIGN: return oa;
      `SIMIL_ADDR_IN_ASSIGN: return ia;
      `SIMIL_ADDR_HOME_METHOD: return hm;
      `SIMIL_ADDR_STATUS: return status_exp();
      default: return 32'h0;
    endcase
  endfunction

  // unassigned stop and limit inputs read on, others off
  function automatic logic fn(input int f);
    logic [3:0] n;
    n = ia[4*f +: 4];
    if (n[3]) return (f == 4 || f == 6 || f == 7);
    return want_pins[n[2:0]];
  endfunction

  // status word as the rules predict it, once the pins have settled
  function automatic logic [31:0] status_exp();
    logic al, fw, rv;
    al = aon[11:8] == `SIMIL_AUTO_LIMITS_ON;
    fw = al || fn(6);
    rv = al || fn(7);
    return {15'h0, !(fw && rv), !(fw && rv), !fn(4), pol[8] ? fn(5) : !fn(5), rv, fw,
            mode_exp, want_pins};
  endfunction

  task automatic check_outs();
    logic fs, lim;
    logic [3:0] op;
    fs = fn(4);
    lim = (aon[11:8] == `SIMIL_AUTO_LIMITS_ON) || (fn(6) && fn(7));
    for (int p = 0; p < 4; p++) begin
      case (oa[8*p +: 8])
        `SIMIL_OUT_TROUBLE: op[p] = !alarm_active;
        `SIMIL_OUT_WARNING: op[p] = lim;
        `SIMIL_OUT_TRAVEL_DONE: op[p] = travel_done;
        `SIMIL_OUT_READY: op[p] = fs && !alarm_active;
        default: op[p] = 1'b0;
      endcase
    end
    if (!motion_busy) mode_exp = !fn(0) ? 3'b001 : (program_has_home ? 3'b100 : 3'b010);
    chk(op_mode, mode_exp);
    chk(program_select, {fn(3), fn(2), fn(1)});
    chk(power_stage_enable, fs);
    chk(dynamic_brake_on, !fs);
    chk(motion_permit, fs && lim && !alarm_active);
    chk(sudden_stop, !lim && !stp[0]);
    chk(servo_lock, !lim);
    chk(slow_stop, !lim && stp[0]);
    chk(proximity_detected, pol[8] ? fn(5) : !fn(5));
    chk(out_pins, op);
  endtask

  task automatic apply(input logic [7:0] p);
    want_pins <= p;
    repeat (DEB + 8) @(posedge aclk);
    check_outs();
  endtask

  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    timeout(n);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, a < `SIMIL_ADDR_STATUS ? `SIMIL_RESP_OKAY : `SIMIL_RESP_SLVERR);
    // narrow registers keep only their low bits
    case (a)
      `SIMIL_ADDR_POLARITY: pol = {16'h0, d[15:0]};
      `SIMIL_ADDR_AUTO_ON: aon = {16'h0, d[15:0]};
      `SIMIL_ADDR_STOP_METHOD: stp = {16'h0, d[15:0]};
      `SIMIL_ADDR_OUT_ASSIGN: oa = d;
      `SIMIL_ADDR_IN_ASSIGN: ia = d;
      `SIMIL_ADDR_HOME_METHOD: hm = {29'h0, d[2:0]};
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    timeout(n);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, regval(a));
    chk(s_axi_rresp, a <= `SIMIL_ADDR_STATUS ? `SIMIL_RESP_OKAY : `SIMIL_RESP_SLVERR);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(80));
    pol = `SIMIL_POLARITY_RST;
    aon = `SIMIL_AUTO_ON_RST;
    stp = `SIMIL_STOP_METHOD_RST;
    oa = `SIMIL_OUT_ASSIGN_RST;
    ia = `SIMIL_IN_ASSIGN_RST;
    hm = `SIMIL_HOME_METHOD_RST;
    mode_exp = 3'b001;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(8'(a * 4));
    wr(`SIMIL_ADDR_STATUS, 32'h1);
    $display("test registers done");
    // configs: default, on-detect, forced limits and slow stop, unassigned forward limit
    for (int c = 0; c < 4; c++) begin
      if (c == 1) wr(`SIMIL_ADDR_POLARITY, 32'h0000_0100);
      if (c == 2) wr(`SIMIL_ADDR_AUTO_ON, 32'h0000_0400);
      if (c == 2) wr(`SIMIL_ADDR_STOP_METHOD, 32'h1);
      if (c == 2) wr(`SIMIL_ADDR_OUT_ASSIGN, 32'h0207_1803);
      if (c == 3) wr(`SIMIL_ADDR_AUTO_ON, 32'h0);
      if (c == 3) wr(`SIMIL_ADDR_IN_ASSIGN, 32'h7f54_3210);
      repeat (8) begin
        alarm_active <= 1'($urandom);
        travel_done <= 1'($urandom);
        want_home <= 1'($urandom);
        apply(8'($urandom));
      end
      apply(8'hc1);
      apply(8'hd1);
    end
    $display("test interlocks done");
    // a glitch shorter than the debounce window must not reach the outputs
    glitch <= 1'b1;
    @(posedge aclk);
    glitch <= 1'b0;
    // outputs must hold through the whole window, not merely settle back
    repeat (DEB + 8) begin
      @(posedge aclk);
      check_outs();
    end
    // select change while moving is held until motion stops
    motion_busy <= 1'b1;
    apply(8'hd0);
    motion_busy <= 1'b0;
    apply(8'hd0);
    $display("test mode hold done");
    for (int m = 0; m < 8; m++) begin
      wr(`SIMIL_ADDR_HOME_METHOD, 32'(m));
      chk(home_method, m);
    end
    wr(`SIMIL_ADDR_HOME_METHOD, 32'h4);
    want_home <= 1'b1;
    apply(8'hd1);
    servo_on <= 1'b1;
    begin
      int hits;
      hits = 0;
      repeat (10) begin
        @(posedge aclk);
        if (home_set_pulse === 1'b1) hits++;
      end
      chk(hits, 1);
    end
    // read back every register after all the writes above
    for (int a = 0; a < 8; a++) rd(8'(a * 4));
    $display("test home done");
    finish_test();
  end
endmodule
